// ===== core/dmbc_pkg.sv
// dmbc_pkg: opcodes, field positions, timing counts and states for the
// configuration/bank-map link; shared by the device end and the controller end.
package dmbc_pkg;
  // command opcodes on the 4-bit command bus
  localparam logic [3:0] OP_ACTIVATE  = 4'h2;
  localparam logic [3:0] OP_PRECHARGE = 4'h3;
  localparam logic [3:0] OP_READ      = 4'h4;
  localparam logic [3:0] OP_MEM_RESET = 4'h6;
  localparam logic [3:0] OP_CFGWR     = 4'h7;
  localparam logic [3:0] OP_MAPWR     = 4'hD;
  localparam logic [3:0] OP_STOP      = 4'hF;
  // configuration word and bank-id fields on the address/data bus
  localparam int PWRDN_BIT = 11;
  localparam int LAT_HI  = 10;
  localparam int LAT_LO  = 8;
  localparam int ID_HI   = 15;
  localparam int ID_LO   = 9;
  localparam int BANK_LO = 8;
  localparam int MAP_W   = 7;
  localparam logic [3:0] LAT_BASE = 4'h3;
  // timing
  localparam int CLK_NS     = 8;
  localparam int REF_MS     = 16;
  localparam int REF_CYCLES = REF_MS * 1000000 / CLK_NS;
  localparam logic [3:0] RAS_CYC    = 4'h4;
  localparam logic [3:0] RP_CYC     = 4'h4;
  localparam logic [3:0] RD_TIMEOUT = 4'hF;
  // controller register offsets and operations
  localparam logic [3:0] REG_OP    = 4'h0;
  localparam logic [3:0] REG_ARG   = 4'h4;
  localparam logic [3:0] REG_STAT  = 4'h8;
  localparam logic [3:0] REG_RDATA = 4'hC;
  localparam logic [1:0] CO_CFG    = 2'h0;
  localparam logic [1:0] CO_MAP    = 2'h1;
  localparam logic [1:0] CO_READ   = 2'h2;
  localparam logic [1:0] CO_RESET  = 2'h3;
  localparam logic [2:0] INIT_LAT_DEF = 3'h2;

  typedef enum logic [3:0] {
    S_RESET = 4'h0, S_STOP1 = 4'h1, S_STOP2 = 4'h2, S_CFG    = 4'h3,
    S_IDLE  = 4'h4, S_MAP2  = 4'h5, S_MAP3  = 4'h6, S_RWAIT  = 4'h7,
    S_RDATA2 = 4'h8, S_RAS  = 4'h9, S_RP    = 4'hA
  } dmbc_state_e;

  // full clock cycles from read command to first data half-word
  function automatic logic [3:0] dmbc_lat_cycles(input logic [2:0] code);
    logic [3:0] edges;
    edges = {1'b0, code} + LAT_BASE + 4'h1;
    return edges >> 1;
  endfunction : dmbc_lat_cycles

  // configuration word with reserved low byte forced to zero
  function automatic logic [15:0] dmbc_cfg_word(input logic pwr_dn, input logic [2:0] lat);
    return {4'h0, pwr_dn, lat, 8'h00};
  endfunction : dmbc_cfg_word
endpackage : dmbc_pkg

// ===== core/dmbc_link_if.sv
// dmbc_link_if: command/address link between controller and device.
// assumes both ends share one clock; the shared bus level is resolved here.
`timescale 1ns/1ps
interface dmbc_link_if;
  logic [3:0]  cmd;
  logic        cs_n;
  logic [15:0] ctl_adq;
  logic        ctl_oe;
  logic [15:0] dev_adq;
  logic        dev_oe;
  logic        dev_fall;
  logic [15:0] adq;

  assign adq = ctl_oe ? ctl_adq : (dev_oe ? dev_adq : 16'h0000);

  modport ctl (output cmd, output cs_n, output ctl_adq, output ctl_oe,
               input adq, input dev_oe, input dev_fall);
  modport dev (input cmd, input cs_n, input adq, input ctl_oe,
               output dev_adq, output dev_oe, output dev_fall);
endinterface : dmbc_link_if

// ===== core/dmbc_device.sv
// dmbc_device: configuration, bank-map and read-latency logic of the memory.
// assumes commands are synchronous to i_ref_clk; i_reset_n stands for power-up.
`timescale 1ns/1ps
module dmbc_device #(
  parameter int NUM_PAIRS = 8
) (
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_reset_n,
  dmbc_link_if.dev                          link,
  output logic                              o_power_down,
  output logic                              o_pll_on,
  output logic [2:0]                        o_latency,
  output logic                              o_latency_set,
  output logic [NUM_PAIRS*dmbc_pkg::MAP_W-1:0] o_bank_map,
  output logic                              o_read_busy
);
  import dmbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic                  pwr_down;
  logic                  next_pwr_down;
  logic                  pll_on;
  logic                  next_pll_on;
  logic [2:0]            lat;
  logic [2:0]            next_lat;
  logic                  lat_set;
  logic                  next_lat_set;
  logic [MAP_W-1:0]      map      [NUM_PAIRS];
  logic [MAP_W-1:0]      next_map [NUM_PAIRS];
  logic                  pend;
  logic                  next_pend;
  logic [MAP_W-1:0]      cur;
  logic [MAP_W-1:0]      next_cur;
  logic [3:0]            rd_cnt;
  logic [3:0]            next_rd_cnt;
  logic [1:0]            rd_ph;
  logic [1:0]            next_rd_ph;
  logic [31:0]           rd_word;
  logic [31:0]           next_rd_word;
  logic                  dev_oe;
  logic                  next_dev_oe;
  logic [15:0]           dev_adq;
  logic [15:0]           next_dev_adq;
  logic                  dev_fall;
  logic                  next_dev_fall;
  logic                  sel;
  logic                  hit;
  logic [MAP_W-1:0]      req_id;

  assign sel    = !link.cs_n;
  assign req_id = link.adq[ID_HI:ID_LO];

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_pwr_down = pwr_down;
    next_lat      = lat;
    next_lat_set  = lat_set;
    next_map      = map;
    next_pend     = 1'b0;
    next_cur      = cur;
    next_rd_cnt   = rd_cnt;
    next_rd_ph    = rd_ph;
    next_rd_word  = rd_word;
    next_dev_oe   = dev_oe;
    next_dev_adq  = dev_adq;
    next_dev_fall = dev_fall;
    hit           = 1'b0;
    for (int i = 0; i < NUM_PAIRS; i++) begin
      if (map[i] == req_id) begin
        hit = 1'b1;
      end
    end

    // latency countdown, then low half-word, then high half-word
    if (rd_cnt != 4'h0) begin
      next_rd_cnt = rd_cnt - 4'h1;
      if (rd_cnt == 4'h1) begin
        next_dev_oe   = 1'b1;
        next_dev_adq  = rd_word[15:0];
        next_dev_fall = lat[0];
        next_rd_ph    = 2'h1;
      end
    end else if (rd_ph == 2'h1) begin
      next_dev_adq = rd_word[31:16];
      next_rd_ph   = 2'h2;
    end else if (rd_ph == 2'h2) begin
      next_dev_oe  = 1'b0;
      next_dev_adq = 16'h0000;
      next_rd_ph   = 2'h0;
    end

    if (sel) begin
      case (link.cmd)
        OP_MEM_RESET: begin
          for (int i = 0; i < NUM_PAIRS; i++) begin
            next_map[i] = MAP_W'(i);
          end
          next_pwr_down = 1'b0;
          next_lat_set = 1'b0;
          next_rd_cnt  = 4'h0;
          next_rd_ph   = 2'h0;
          next_dev_oe  = 1'b0;
        end
        OP_CFGWR: begin
          // top nibble and low byte are not looked at
          next_pwr_down = link.adq[PWRDN_BIT];
          next_lat     = link.adq[LAT_HI:LAT_LO];
          next_lat_set = 1'b1;
        end
        OP_MAPWR: begin
          if (!pwr_down) begin
            next_pend = 1'b1;
            next_cur  = req_id;
          end
        end
        OP_STOP: begin
          if (pend) begin
            for (int i = 0; i < NUM_PAIRS; i++) begin
              if (map[i] == cur) begin
                next_map[i] = req_id;
              end
            end
          end else if (rd_cnt != 4'h0 || rd_ph != 2'h0) begin
            next_rd_cnt  = 4'h0;
            next_rd_ph   = 2'h0;
            next_dev_oe  = 1'b0;
          end
        end
        OP_PRECHARGE: begin
          next_rd_cnt = 4'h0;
          next_rd_ph  = 2'h0;
          next_dev_oe = 1'b0;
        end
        OP_READ: begin
          if (!pwr_down && lat_set && hit && rd_cnt == 4'h0 && rd_ph == 2'h0) begin
            next_rd_cnt  = dmbc_lat_cycles(lat);
            next_rd_word = {1'b0, req_id, ~link.adq[7:0], link.adq};
          end
        end
        default: begin
        end
      endcase
    end
    next_pll_on = !next_pwr_down;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pwr_down <= 1'b0;
      pll_on   <= 1'b1;
      lat      <= 3'h0;
      lat_set  <= 1'b0;
      for (int i = 0; i < NUM_PAIRS; i++) begin
        map[i] <= MAP_W'(i);
      end
      pend     <= 1'b0;
      cur      <= '0;
      rd_cnt   <= 4'h0;
      rd_ph    <= 2'h0;
      rd_word  <= 32'h0000_0000;
      dev_oe   <= 1'b0;
      dev_adq  <= 16'h0000;
      dev_fall <= 1'b0;
    end else begin
      pwr_down <= next_pwr_down;
      pll_on   <= next_pll_on;
      lat      <= next_lat;
      lat_set  <= next_lat_set;
      map      <= next_map;
      pend     <= next_pend;
      cur      <= next_cur;
      rd_cnt   <= next_rd_cnt;
      rd_ph    <= next_rd_ph;
      rd_word  <= next_rd_word;
      dev_oe   <= next_dev_oe;
      dev_adq  <= next_dev_adq;
      dev_fall <= next_dev_fall;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign link.dev_oe   = dev_oe;
  assign link.dev_adq  = dev_adq;
  assign link.dev_fall = dev_fall;
  assign o_power_down  = pwr_down;
  assign o_pll_on      = pll_on;
  assign o_latency     = lat;
  assign o_latency_set = lat_set;
  assign o_read_busy   = dev_oe;

  for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_map
    assign o_bank_map[g*MAP_W +: MAP_W] = map[g];
  end
endmodule : dmbc_device

// ===== core/dmbc_ctrl.sv
// dmbc_ctrl: memory controller end; initialises, refreshes and issues
// config, bank-map and read sequences ordered over Avalon-MM.
// assumes one shared clock with the device end.
`timescale 1ns/1ps
module dmbc_ctrl #(
  parameter logic [2:0] INIT_LAT   = dmbc_pkg::INIT_LAT_DEF,
  parameter int         REF_CYCLES = dmbc_pkg::REF_CYCLES,
  parameter int         ROWS       = 32,
  parameter int         BANKS      = 16
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  dmbc_link_if.ctl         link
);
  import dmbc_pkg::*;
  localparam int TW = $clog2(REF_CYCLES + 1);

  dmbc_state_e  state;
  dmbc_state_e  next_state;
  logic [3:0]   cnt;
  logic [3:0]   next_cnt;
  logic [TW-1:0] tmr;
  logic [TW-1:0] next_tmr;
  logic         due;
  logic         next_due;
  logic [7:0]   row;
  logic [7:0]   next_row;
  logic [7:0]   bank;
  logic [7:0]   next_bank;
  logic         go;
  logic         next_go;
  logic [1:0]   op;
  logic [1:0]   next_op;
  logic [31:0]  arg;
  logic [31:0]  next_arg;
  logic [31:0]  rdata;
  logic [31:0]  next_rdata;
  logic         err;
  logic         next_err;
  logic         init_done;
  logic         next_init_done;
  logic [3:0]   cmd;
  logic [3:0]   next_cmd;
  logic         cs_n;
  logic         next_cs_n;
  logic [15:0]  adq;
  logic [15:0]  next_adq;
  logic         oe;
  logic         next_oe;
  logic         wait_r;
  logic         next_wait;
  logic [31:0]  rd_out;
  logic [31:0]  next_rd_out;
  logic         busy;
  logic         req;

  assign busy = go || state != S_IDLE;
  assign req  = i_read || i_write;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_row = row;
    next_bank = bank;
    next_go = go;
    next_op = op;
    next_arg = arg;
    next_rdata = rdata;
    next_err = err;
    next_init_done = init_done;
    next_cmd = OP_STOP;
    next_cs_n = 1'b1;
    next_adq = 16'h0000;
    next_oe = 1'b0;
    next_due = due;
    next_tmr = tmr - TW'(1);
    next_wait = 1'b1;
    next_rd_out = rd_out;

    // Avalon slave: one wait cycle, OP writes stall while busy
    if (req && wait_r && !(i_write && i_address == REG_OP && busy)) begin
      next_wait = 1'b0;
      case (i_address)
        REG_ARG:   next_rd_out = arg;
        REG_STAT:  next_rd_out = {28'h0, err, due, init_done, busy};
        REG_RDATA: next_rd_out = rdata;
        default:   next_rd_out = 32'h0000_0000;
      endcase
    end
    if (i_write && !wait_r) begin
      if (i_address == REG_ARG) begin
        next_arg = i_writedata;
      end else if (i_address == REG_OP) begin
        next_go  = 1'b1;
        next_op  = i_writedata[1:0];
        next_err = 1'b0;
      end
    end

    case (state)
      S_RESET: begin
        next_init_done = 1'b0;
        next_cmd = OP_MEM_RESET;
        next_cs_n = 1'b0;
        next_oe = 1'b1;
        next_state = S_STOP1;
      end
      S_STOP1, S_STOP2: begin
        next_cs_n = 1'b0;
        next_oe = 1'b1;
        next_state = (state == S_STOP1) ? S_STOP2 : S_CFG;
      end
      S_CFG: begin
        next_cmd = OP_CFGWR;
        next_cs_n = 1'b0;
        next_oe = 1'b1;
        next_adq = dmbc_cfg_word(1'b0, INIT_LAT);
        next_init_done = 1'b1;
        next_state = S_IDLE;
      end
      S_IDLE: begin
        if (due) begin
          next_due = 1'b0;
          next_row = 8'h00;
          next_bank = 8'h00;
          next_cnt = 4'h0;
          next_cmd = OP_ACTIVATE;
          next_cs_n = 1'b0;
          next_oe = 1'b1;
          next_state = S_RAS;
        end else if (go) begin
          next_go = 1'b0;
          next_cs_n = 1'b0;
          next_oe = 1'b1;
          next_cnt = 4'h0;
          case (op)
            CO_CFG: begin
              next_cmd = OP_CFGWR;
              next_adq = dmbc_cfg_word(arg[PWRDN_BIT], arg[LAT_HI:LAT_LO]);
            end
            CO_MAP: begin
              next_cmd = OP_MAPWR;
              next_adq = {arg[6:0], 9'h000};
              next_state = S_MAP2;
            end
            CO_READ: begin
              next_cmd = OP_READ;
              next_adq = arg[15:0];
              next_state = S_RWAIT;
            end
            default: begin
              next_cs_n = 1'b1;
              next_oe = 1'b0;
              next_state = S_RESET;
            end
          endcase
        end
      end
      S_MAP2: begin
        next_cs_n = 1'b0;
        next_oe = 1'b1;
        next_adq = {arg[22:16], 9'h000};
        next_state = S_MAP3;
      end
      S_MAP3: begin
        next_cs_n = 1'b0;
        next_oe = 1'b1;
        next_state = S_IDLE;
      end
      S_RWAIT: begin
        next_cmd = OP_READ;
        next_cs_n = 1'b0;
        if (link.dev_oe) begin
          next_rdata[15:0] = link.adq;
          next_state = S_RDATA2;
        end else if (cnt == RD_TIMEOUT) begin
          next_err = 1'b1;
          next_cs_n = 1'b0;
          next_oe = 1'b1;
          next_cmd = OP_STOP;
          next_state = S_IDLE;
        end else begin
          next_cnt = cnt + 4'h1;
        end
      end
      S_RDATA2: begin
        next_rdata[31:16] = link.adq;
        next_cs_n = 1'b0;
        next_oe = 1'b1;
        next_state = S_IDLE;
      end
      S_RAS: begin
        next_cnt = cnt + 4'h1;
        if (cnt == RAS_CYC - 4'h1) begin
          next_cmd = OP_PRECHARGE;
          next_cs_n = 1'b0;
          next_oe = 1'b1;
          next_adq = {bank, 8'h00};
          next_cnt = 4'h0;
          next_state = S_RP;
        end
      end
      S_RP: begin
        next_cnt = cnt + 4'h1;
        if (cnt == RP_CYC - 4'h1) begin
          next_cnt = 4'h0;
          if (row == 8'(ROWS - 1) && bank == 8'(BANKS - 1)) begin
            next_state = S_IDLE;
          end else begin
            if (row == 8'(ROWS - 1)) begin
              next_row = 8'h00;
              next_bank = bank + 8'h01;
            end else begin
              next_row = row + 8'h01;
            end
            next_cmd = OP_ACTIVATE;
            next_cs_n = 1'b0;
            next_oe = 1'b1;
            next_state = S_RAS;
          end
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase

    // interval tick; set wins over the sweep's clear
    if (tmr == '0) begin
      next_tmr = TW'(REF_CYCLES - 1);
      next_due = 1'b1;
    end
    if (next_state == S_RAS || next_state == S_RP) begin
      next_adq = (next_cmd == OP_ACTIVATE) ? {next_bank, next_row} : next_adq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= S_RESET;
      cnt <= 4'h0;
      tmr <= '0;
      due <= 1'b0;
      row <= 8'h00;
      bank <= 8'h00;
      go <= 1'b0;
      op <= 2'h0;
      arg <= 32'h0000_0000;
      rdata <= 32'h0000_0000;
      err <= 1'b0;
      init_done <= 1'b0;
      cmd <= 4'hF;
      cs_n <= 1'b1;
      adq <= 16'h0000;
      oe <= 1'b0;
      wait_r <= 1'b1;
      rd_out <= 32'h0000_0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      tmr <= next_tmr;
      due <= next_due;
      row <= next_row;
      bank <= next_bank;
      go <= next_go;
      op <= next_op;
      arg <= next_arg;
      rdata <= next_rdata;
      err <= next_err;
      init_done <= next_init_done;
      cmd <= next_cmd;
      cs_n <= next_cs_n;
      adq <= next_adq;
      oe <= next_oe;
      wait_r <= next_wait;
      rd_out <= next_rd_out;
    end
  end

  assign link.cmd     = cmd;
  assign link.cs_n    = cs_n;
  assign link.ctl_adq = adq;
  assign link.ctl_oe  = oe;
  assign o_readdata    = rd_out;
  assign o_waitrequest = wait_r;
endmodule : dmbc_ctrl

// ===== dv/dmbc_checker.sv
// dmbc_checker: link checks between the controller end and the device end.
// assumes one clock; sits beside the link interface in the bench top.
`timescale 1ns/1ps
module dmbc_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  input wire logic [3:0]  cmd,
  input wire logic        cs_n,
  input wire logic [15:0] ctl_adq,
  input wire logic        ctl_oe,
  input wire logic [15:0] dev_adq,
  input wire logic        dev_oe,
  input wire logic        dev_fall,
  input wire logic [15:0] adq
);
  import dmbc_pkg::*;
  logic [2:0]  lat;
  logic [2:0]  next_lat;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [15:0] word;
  logic [15:0] next_word;
  logic        rd_q;
  logic        next_rd_q;
  logic [3:0]  edges;
  logic [3:0]  k_exp;
  ////////////////////////////////////////////////////////////////////////////
  // latency code and read start as seen on the wire
  always_comb begin
    next_lat = lat;
    next_word = word;
    next_rd_q = !cs_n && cmd == OP_READ;
    next_cnt = (cnt == 4'hF) ? cnt : cnt + 4'h1;
    if (!cs_n && cmd == OP_CFGWR) begin
      next_lat = adq[LAT_HI:LAT_LO];
    end
    if (next_rd_q && !rd_q) begin
      next_cnt = 4'h1;
      next_word = adq;
    end
    edges = {1'b0, lat} + 4'h3;
    // latency edges rounded up to whole cycles; cnt is 1 at the read edge
    k_exp = ((edges + 4'h1) >> 1) + 4'h1;
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lat <= 3'h0;
      cnt <= 4'hF;
      word <= 16'h0000;
      rd_q <= 1'b0;
    end else begin
      lat <= next_lat;
      cnt <= next_cnt;
      word <= next_word;
      rd_q <= next_rd_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_boot;
    (cmd == OP_MEM_RESET && !cs_n) ##[1:4] (cmd == OP_CFGWR && !cs_n);
  endsequence
  sequence s_map_tail;
    cmd == OP_STOP ##1 cmd == OP_STOP;
  endsequence
  sequence s_halves;
    adq == word ##1 adq == {1'b0, word[15:9], ~word[7:0]};
  endsequence
  property p_boot; $rose(i_reset_n) |-> ##[0:3] s_boot; endproperty
  property p_cfg_low; !cs_n && cmd == OP_CFGWR |-> adq[7:0] == 8'h00; endproperty
  property p_map; !cs_n && cmd == OP_MAPWR |=> s_map_tail; endproperty
  property p_lat; $rose(dev_oe) |-> cnt == k_exp; endproperty
  property p_edge; $rose(dev_oe) |-> dev_fall == lat[0]; endproperty
  property p_burst; $rose(dev_oe) |=> dev_oe ##1 !dev_oe; endproperty
  property p_half; $rose(dev_oe) |-> s_halves; endproperty
  property p_bus; dev_oe |-> !ctl_oe; endproperty
  property p_ref; !cs_n && cmd == OP_ACTIVATE |-> ##[1:8] cmd == OP_PRECHARGE; endproperty
  a_boot: assert property (p_boot) else $error("no reset then config at start");
  a_cfg_low: assert property (p_cfg_low) else $error("config low byte not zero");
  a_map: assert property (p_map) else $error("map write not followed by stops");
  a_lat: assert property (p_lat) else $error("first read data off latency");
  a_edge: assert property (p_edge) else $error("first half-word on wrong edge");
  a_burst: assert property (p_burst) else $error("read data not two half-words");
  a_half: assert property (p_half) else $error("read half-words wrong");
  a_bus: assert property (p_bus) else $error("both ends drive the bus");
  a_ref: assert property (p_ref) else $error("activate without precharge");
endmodule : dmbc_checker

// ===== dv/dmbc_tb.sv
// dmbc_tb: controller and device joined over the link, driven over Avalon-MM;
// a second device is driven directly to try an unselected bank-map write.
`timescale 1ns/1ps
module dmbc_tb;
  import dmbc_pkg::*;
  localparam int NP = 8;
  logic                  i_ref_clk = 1'b0;
  logic                  i_reset_n = 1'b0;
  logic [3:0]            address = 4'h0;
  logic                  read = 1'b0;
  logic                  write = 1'b0;
  logic [31:0]           writedata = 32'h0;
  logic [31:0]           readdata;
  logic                  waitrequest;
  logic                  pwr_down;
  logic                  pll;
  logic                  lat_set;
  logic [2:0]            lat;
  logic [NP*MAP_W-1:0]   map;
  logic [NP*MAP_W-1:0]   map2;
  int                    err_count = 0;
  int                    n_tests = 0;
  int                    cycles = 0;
  dmbc_link_if link ();
  dmbc_link_if link2 ();
  dmbc_ctrl #(.REF_CYCLES(400), .ROWS(2), .BANKS(2)) dmbc_ctrl_i (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_address(address), .i_read(read),
    .i_write(write), .i_writedata(writedata), .o_readdata(readdata),
    .o_waitrequest(waitrequest), .link(link));
  dmbc_device #(.NUM_PAIRS(NP)) dmbc_device_i (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .link(link), .o_power_down(pwr_down),
    .o_pll_on(pll), .o_latency(lat), .o_latency_set(lat_set), .o_bank_map(map),
    .o_read_busy());
  dmbc_device #(.NUM_PAIRS(NP)) dmbc_device_i2 (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .link(link2), .o_power_down(),
    .o_pll_on(), .o_latency(), .o_latency_set(), .o_bank_map(map2), .o_read_busy());
  dmbc_checker dmbc_checker_i (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .cmd(link.cmd), .cs_n(link.cs_n),
    .ctl_adq(link.ctl_adq), .ctl_oe(link.ctl_oe), .dev_adq(link.dev_adq),
    .dev_oe(link.dev_oe), .dev_fall(link.dev_fall), .adq(link.adq));
  initial begin
    link2.cmd = OP_STOP;
    link2.cs_n = 1'b1;
    link2.ctl_adq = 16'h0000;
    link2.ctl_oe = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      $display("BAD run stopped by timeout");
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge i_ref_clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do @(posedge i_ref_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : av
  task automatic op(input logic [1:0] o, input logic [31:0] arg, output logic [31:0] st);
    av(1'b1, REG_ARG, arg, st);
    av(1'b1, REG_OP, {30'h0, o}, st);
    do av(1'b0, REG_STAT, 32'h0, st); while (st[0] !== 1'b0);
  endtask : op
  task automatic rd(input logic [15:0] w, output logic [31:0] q, output logic [31:0] st);
    op(CO_READ, {16'h0, w}, st);
    av(1'b0, REG_RDATA, 32'h0, q);
  endtask : rd
  task automatic send(input logic cs_n, input logic [3:0] c, input logic [15:0] d);
    @(posedge i_ref_clk);
    link2.cs_n <= cs_n;
    link2.cmd <= c;
    link2.ctl_adq <= d;
    link2.ctl_oe <= 1'b1;
  endtask : send
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_init();
    logic [31:0] q;
    do av(1'b0, REG_STAT, 32'h0, q); while (q[1] !== 1'b1);
    check("power_down", 32'(pwr_down), 32'h0);
    check("pll_on", 32'(pll), 32'h1);
    check("latency", 32'(lat), 32'(INIT_LAT_DEF));
    check("latency_set", 32'(lat_set), 32'h1);
    for (int i = 0; i < NP; i++) begin
      check("bank_map", 32'(map[i*MAP_W+:MAP_W]), i);
    end
    $display("t_init done");
  endtask : t_init
  task automatic t_latency();
    logic [31:0] q;
    logic [31:0] st;
    logic [15:0] w;
    for (int c = 0; c < 8; c++) begin
      op(CO_CFG, 32'h0000F000 | (c << 8), st);
      check("latency", 32'(lat), c);
      w = {4'h0, 3'(c), 1'b1, 8'h5A};
      rd(w, q, st);
      check("read data", q, {1'b0, w[15:9], ~w[7:0], w});
    end
    $display("t_latency done");
  endtask : t_latency
  task automatic t_power();
    logic [31:0] q;
    logic [31:0] st;
    op(CO_CFG, 32'h00000B00, st);
    check("power_down", 32'(pwr_down), 32'h1);
    check("pll_on", 32'(pll), 32'h0);
    check("latency", 32'(lat), 32'h3);
    rd(16'h0300, q, st);
    check("read refused", 32'(st[3]), 32'h1);
    op(CO_CFG, 32'h00000200, st);
    check("pll_on", 32'(pll), 32'h1);
    $display("t_power done");
  endtask : t_power
  task automatic t_map();
    logic [31:0] q;
    logic [31:0] st;
    op(CO_MAP, 32'h000A0000, st);
    check("bank_map", 32'(map[MAP_W-1:0]), 32'h0A);
    check("bank_map", 32'(map[2*MAP_W-1:MAP_W]), 32'h01);
    rd(16'h1400, q, st);
    check("read remapped", q, 32'h0AFF1400);
    rd(16'h0000, q, st);
    check("old id refused", 32'(st[3]), 32'h1);
    op(CO_RESET, 32'h0, st);
    t_init();
    $display("t_map done");
  endtask : t_map
  task automatic t_chipsel();
    send(1'b1, OP_MAPWR, 16'h0000);
    send(1'b1, OP_STOP, {7'h11, 9'h0});
    send(1'b1, OP_STOP, 16'h0000);
    send(1'b1, OP_STOP, 16'h0000);
    check("unselected map", 32'(map2[MAP_W-1:0]), 32'h0);
    send(1'b0, OP_MAPWR, 16'h0000);
    send(1'b0, OP_STOP, {7'h11, 9'h0});
    send(1'b0, OP_STOP, 16'h0000);
    send(1'b1, OP_STOP, 16'h0000);
    check("selected map", 32'(map2[MAP_W-1:0]), 32'h11);
    $display("t_chipsel done");
  endtask : t_chipsel
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    t_init();
    t_latency();
    t_power();
    t_map();
    t_chipsel();
    @(posedge i_ref_clk);
    i_reset_n <= 1'b0;
    repeat (12) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    t_init();
    check("map after power", 32'(map2[MAP_W-1:0]), 32'h0);
    give_verdict();
  end
endmodule : dmbc_tb
